// >>> core/vwin_params.svh
// register offsets, field positions and reset values for the video window block
`ifndef VWIN_PARAMS_SVH
`define VWIN_PARAMS_SVH
`define OFS_LEFT_REGION_SIZE 12'h000
`define OFS_WINDOW_WIDTH 12'h004
`define OFS_VIDEO_SOURCE_SIZE 12'h008
`define OFS_HORIZONTAL_OVERFLOW 12'h00c
`define OFS_VERTICAL_START 12'h010
`define OFS_VERTICAL_END 12'h014
`define OFS_VERTICAL_OVERFLOW 12'h018
`define OFS_BUFFER_ONE_LOW 12'h01c
`define OFS_BUFFER_ONE_MID 12'h020
`define OFS_BUFFER_ONE_HIGH 12'h024
`define OFS_LINE_OFFSET_LOW 12'h028
`define OFS_WINDOW_CONTROL 12'h02c
`define OFS_ADJUST_BITS 12'h030
`define OFS_SWITCH_CONTROL 12'h034
`define OFS_BUFFER_TWO_HIGH 12'h038
`define OFS_BUFFER_TWO_LOW 12'h03c
`define OFS_BUFFER_TWO_MID 12'h040
`define OFS_STATUS 12'h044
`define BIT_MASTER_ENABLE 0
`define BIT_OCCLUSION 7
`define BIT_LINE_OFFSET_HI 5
`define POS_SWITCH_MODE 3
`define REG_RESET 8'h00
`endif

// >>> core/vwin_pkg.sv
// types shared by the video window fetch block
package vwin_pkg;
  typedef enum logic [1:0] {
    BPP_8 = 2'b00,
    BPP_16 = 2'b01,
    BPP_24 = 2'b10,
    BPP_32 = 2'b11
  } bpp_type;
  typedef enum logic [1:0] {
    REGION_LEFT = 2'b00,
    REGION_WINDOW = 2'b01,
    REGION_RIGHT = 2'b10
  } region_type;
  typedef enum logic [1:0] {
    SWITCH_FIXED_ONE = 2'b00,
    SWITCH_FIXED_TWO = 2'b01,
    SWITCH_AUTO_VREF = 2'b10,
    SWITCH_ON_BLIT = 2'b11
  } switch_type;
endpackage

// >>> core/video_window_overlay_fetch.sv
// video window overlay: region timing, buffer select and video fetch addressing
`timescale 1ns/1ps
`default_nettype none
`include "vwin_params.svh"
module video_window_overlay_fetch (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // display timing from the refresh pipeline
  input wire logic vsync,
  input wire logic line_start,
  input wire logic [9:0] scanline,
  input wire logic dword_strobe,
  input wire vwin_pkg::bpp_type graphics_bpp,
  input wire logic interlaced,
  input wire logic blit_done,
  // fetch and pixel select outputs
  output logic graphics_fetch,
  output logic video_fetch,
  output logic [21:0] video_addr,
  output logic show_video,
  output logic [5:0] window_pixel_adjust,
  output logic display_buffer
);
  import vwin_pkg::*;

  logic [7:0] left_region_size_reg, window_width_reg, video_source_size_reg;
  logic [7:0] horizontal_overflow_reg, vertical_start_reg, vertical_end_reg;
  logic [7:0] vertical_overflow_reg, buffer_one_addr_low, buffer_one_addr_mid;
  logic [7:0] buffer_one_addr_high, line_offset_low, video_window_control;
  logic [7:0] window_adjust_bits, buffer_switch_control;
  logic [7:0] buffer_two_addr_high, buffer_two_addr_low, buffer_two_addr_mid;
  logic [2:0] vsync_sync, blit_sync, line_start_sync;
  logic [9:0] line_sync1, line_sync2;
  logic [1:0] strobe_sync;
  logic enable_active, swap_pending, odd_field, in_lines, next_display_buffer;
  region_type region;
  logic [10:0] dword_count, video_count;
  logic [21:0] line_base;
  logic [9:0] left_region_dwords, window_width_dwords, video_source_dword_count;
  logic [9:0] window_vertical_start, window_vertical_end;
  logic [1:0] left_region_byte_adjust, window_width_byte_adjust;
  logic [11:0] video_line_offset;
  logic [21:0] video_buffer_one_start, video_buffer_two_start;
  logic access, vsync_rise, line_pulse, strobe_pulse, blit_pulse;

  // apb write and read
  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left_region_size_reg <= `REG_RESET;
      window_width_reg <= `REG_RESET;
      video_source_size_reg <= `REG_RESET;
      horizontal_overflow_reg <= `REG_RESET;
      vertical_start_reg <= `REG_RESET;
      vertical_end_reg <= `REG_RESET;
      vertical_overflow_reg <= `REG_RESET;
      buffer_one_addr_low <= `REG_RESET;
      buffer_one_addr_mid <= `REG_RESET;
      buffer_one_addr_high <= `REG_RESET;
      line_offset_low <= `REG_RESET;
      video_window_control <= `REG_RESET;
      window_adjust_bits <= `REG_RESET;
      buffer_switch_control <= `REG_RESET;
      buffer_two_addr_high <= `REG_RESET;
      buffer_two_addr_low <= `REG_RESET;
      buffer_two_addr_mid <= `REG_RESET;
    end else if (access && pwrite) begin
      unique case (paddr)
        `OFS_LEFT_REGION_SIZE: left_region_size_reg <= pwdata[7:0];
        `OFS_WINDOW_WIDTH: window_width_reg <= pwdata[7:0];
        `OFS_VIDEO_SOURCE_SIZE: video_source_size_reg <= pwdata[7:0];
        `OFS_HORIZONTAL_OVERFLOW: horizontal_overflow_reg <= pwdata[7:0];
        `OFS_VERTICAL_START: vertical_start_reg <= pwdata[7:0];
        `OFS_VERTICAL_END: vertical_end_reg <= pwdata[7:0];
        `OFS_VERTICAL_OVERFLOW: vertical_overflow_reg <= pwdata[7:0];
        `OFS_BUFFER_ONE_LOW: buffer_one_addr_low <= pwdata[7:0];
        `OFS_BUFFER_ONE_MID: buffer_one_addr_mid <= pwdata[7:0];
        `OFS_BUFFER_ONE_HIGH: buffer_one_addr_high <= pwdata[7:0];
        `OFS_LINE_OFFSET_LOW: line_offset_low <= pwdata[7:0];
        `OFS_WINDOW_CONTROL: video_window_control <= pwdata[7:0];
        `OFS_ADJUST_BITS: window_adjust_bits <= pwdata[7:0];
        `OFS_SWITCH_CONTROL: buffer_switch_control <= pwdata[7:0];
        `OFS_BUFFER_TWO_HIGH: buffer_two_addr_high <= pwdata[7:0];
        `OFS_BUFFER_TWO_LOW: buffer_two_addr_low <= pwdata[7:0];
        `OFS_BUFFER_TWO_MID: buffer_two_addr_mid <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      `OFS_LEFT_REGION_SIZE: prdata[7:0] = left_region_size_reg;
      `OFS_WINDOW_WIDTH: prdata[7:0] = window_width_reg;
      `OFS_VIDEO_SOURCE_SIZE: prdata[7:0] = video_source_size_reg;
      `OFS_HORIZONTAL_OVERFLOW: prdata[7:0] = horizontal_overflow_reg;
      `OFS_VERTICAL_START: prdata[7:0] = vertical_start_reg;
      `OFS_VERTICAL_END: prdata[7:0] = vertical_end_reg;
      `OFS_VERTICAL_OVERFLOW: prdata[7:0] = vertical_overflow_reg;
      `OFS_BUFFER_ONE_LOW: prdata[7:0] = buffer_one_addr_low;
      `OFS_BUFFER_ONE_MID: prdata[7:0] = buffer_one_addr_mid;
      `OFS_BUFFER_ONE_HIGH: prdata[7:0] = buffer_one_addr_high;
      `OFS_LINE_OFFSET_LOW: prdata[7:0] = line_offset_low;
      `OFS_WINDOW_CONTROL: prdata[7:0] = video_window_control;
      `OFS_ADJUST_BITS: prdata[7:0] = window_adjust_bits;
      `OFS_SWITCH_CONTROL: prdata[7:0] = buffer_switch_control;
      `OFS_BUFFER_TWO_HIGH: prdata[7:0] = buffer_two_addr_high;
      `OFS_BUFFER_TWO_LOW: prdata[7:0] = buffer_two_addr_low;
      `OFS_BUFFER_TWO_MID: prdata[7:0] = buffer_two_addr_mid;
      `OFS_STATUS: prdata[3:0] = {in_lines, region == REGION_WINDOW,
                                  display_buffer, enable_active};
      default: ;
    endcase
  end

  // field assembly from loose register bits
  assign left_region_dwords = {horizontal_overflow_reg[1:0], left_region_size_reg};
  assign window_width_dwords = {horizontal_overflow_reg[3:2], window_width_reg};
  assign video_source_dword_count = {horizontal_overflow_reg[5:4], video_source_size_reg};
  assign window_vertical_start = {vertical_overflow_reg[1:0], vertical_start_reg};
  assign window_vertical_end = {vertical_overflow_reg[3:2], vertical_end_reg};
  // no sub-dword adjust at 24 bpp, pixels straddle dwords
  assign left_region_byte_adjust = (graphics_bpp == BPP_24) ? 2'b00 :
                                   window_adjust_bits[1:0];
  assign window_width_byte_adjust = (graphics_bpp == BPP_24) ? 2'b00 :
                                    window_adjust_bits[5:4];
  assign video_buffer_one_start = {buffer_one_addr_high[3:0], buffer_one_addr_mid,
                                   buffer_one_addr_low, window_adjust_bits[3:2]};
  assign video_buffer_two_start = {buffer_two_addr_high[3:0], buffer_two_addr_mid,
                                   buffer_two_addr_low, window_adjust_bits[3:2]};
  assign video_line_offset = {buffer_one_addr_high[`BIT_LINE_OFFSET_HI],
                              line_offset_low, 3'b000};

  // pin synchronisers; first stage read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vsync_sync <= 3'b000;
      blit_sync <= 3'b000;
      line_start_sync <= 3'b000;
      strobe_sync <= 2'b00;
      line_sync1 <= 10'h000;
      line_sync2 <= 10'h000;
    end else begin
      vsync_sync <= {vsync_sync[1:0], vsync};
      blit_sync <= {blit_sync[1:0], blit_done};
      line_start_sync <= {line_start_sync[1:0], line_start};
      strobe_sync <= {strobe_sync[0], dword_strobe};
      line_sync1 <= scanline;
      line_sync2 <= line_sync1;
    end
  end
  assign vsync_rise = vsync_sync[1] && !vsync_sync[2];
  assign blit_pulse = blit_sync[1] && !blit_sync[2];
  // line_start may stand several cycles; a level would step the pitch twice
  assign line_pulse = line_start_sync[1] && !line_start_sync[2];
  assign strobe_pulse = strobe_sync[1];

  // master enable applied at vsync leading edge only
  always_ff @(posedge clk) begin
    if (!rst_n) enable_active <= 1'b0;
    else if (vsync_rise) enable_active <= video_window_control[`BIT_MASTER_ENABLE];
  end

  // buffer for this refresh, shared by the latch and the same-edge address load
  always_comb begin
    next_display_buffer = display_buffer;
    unique case (switch_type'(buffer_switch_control[`POS_SWITCH_MODE+1:`POS_SWITCH_MODE]))
      SWITCH_FIXED_ONE: next_display_buffer = 1'b0;
      SWITCH_FIXED_TWO: next_display_buffer = 1'b1;
      default: if (swap_pending) next_display_buffer = !display_buffer;
    endcase
  end

  // buffer switch triggers, latched at window top
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      swap_pending <= 1'b0;
      odd_field <= 1'b0;
      display_buffer <= 1'b0;
    end else begin
      if (vsync_rise) odd_field <= !odd_field;
      unique case (switch_type'(buffer_switch_control[`POS_SWITCH_MODE+1:`POS_SWITCH_MODE]))
        SWITCH_AUTO_VREF:
          if (vsync_rise && (!interlaced || odd_field)) swap_pending <= 1'b1;
        SWITCH_ON_BLIT:
          if (blit_pulse) swap_pending <= 1'b1;
        default: swap_pending <= 1'b0;
      endcase
      if (line_pulse && line_sync2 == window_vertical_start) begin
        display_buffer <= next_display_buffer;
        // a trigger landing on the latch edge still counts next refresh
        if (!(vsync_rise || blit_pulse)) swap_pending <= 1'b0;
      end
    end
  end

  // vertical extent, inclusive on both ends
  assign in_lines = enable_active && line_sync2 >= window_vertical_start &&
                    line_sync2 <= window_vertical_end;

  // horizontal region counting in graphics dwords
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      region <= REGION_LEFT;
      dword_count <= 11'h000;
    end else if (line_pulse) begin
      region <= (left_region_dwords == 10'h000) ? REGION_WINDOW : REGION_LEFT;
      dword_count <= 11'h000;
    end else if (strobe_pulse) begin
      unique case (region)
        REGION_LEFT:
          if (dword_count + 11'h001 >= {1'b0, left_region_dwords}) begin
            region <= REGION_WINDOW;
            dword_count <= 11'h000;
          end else dword_count <= dword_count + 11'h001;
        REGION_WINDOW:
          if (dword_count + 11'h001 >= {1'b0, window_width_dwords}) begin
            region <= REGION_RIGHT;
            dword_count <= 11'h000;
          end else dword_count <= dword_count + 11'h001;
        REGION_RIGHT: dword_count <= dword_count;
        default: region <= REGION_LEFT;
      endcase
    end
  end

  // adjust bytes as pixels past the boundary: (adjust*8)/bpp
  function automatic logic [5:0] adjust_pixels(input logic [1:0] adj, input bpp_type bpp);
    unique case (bpp)
      BPP_8: adjust_pixels = {4'h0, adj};
      BPP_16: adjust_pixels = {5'h00, adj[1]};
      default: adjust_pixels = 6'h00;
    endcase
  endfunction

  assign show_video = in_lines && region == REGION_WINDOW;
  // occlusion off: graphics under the window skipped to save bandwidth
  assign graphics_fetch = strobe_pulse && !(show_video &&
                          !video_window_control[`BIT_OCCLUSION]);
  assign window_pixel_adjust = (region == REGION_LEFT) ?
      adjust_pixels(left_region_byte_adjust, graphics_bpp) :
      adjust_pixels(window_width_byte_adjust, graphics_bpp);

  // video fetch address, stepped by pitch per window line
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_base <= 22'h000000;
      video_addr <= 22'h000000;
      video_count <= 11'h000;
      video_fetch <= 1'b0;
    end else begin
      video_fetch <= 1'b0;
      if (line_pulse) begin
        if (line_sync2 == window_vertical_start) begin
          line_base <= next_display_buffer ? video_buffer_two_start : video_buffer_one_start;
          video_addr <= next_display_buffer ? video_buffer_two_start : video_buffer_one_start;
        end else if (in_lines) begin
          line_base <= line_base + {10'h000, video_line_offset};
          video_addr <= line_base + {10'h000, video_line_offset};
        end
        video_count <= 11'h000;
      end else if (show_video && video_count < {1'b0, video_source_dword_count}) begin
        video_fetch <= 1'b1;
        video_count <= video_count + 11'h001;
        if (video_fetch) video_addr <= video_addr + 22'h000004;
      end
    end
  end

  a_enable_at_vsync: assert property (@(posedge clk) disable iff (!rst_n)
    !vsync_rise |=> $stable(enable_active))
    else $error("enable changed outside vsync edge");
  a_video_inside_lines: assert property (@(posedge clk) disable iff (!rst_n)
    show_video |-> line_sync2 >= window_vertical_start && line_sync2 <= window_vertical_end)
    else $error("video shown outside window lines");
  a_no_gfx_under: assert property (@(posedge clk) disable iff (!rst_n)
    show_video && !video_window_control[`BIT_OCCLUSION] |-> !graphics_fetch)
    else $error("graphics fetched under window");
  a_zero_left_region: assert property (@(posedge clk) disable iff (!rst_n)
    line_pulse && left_region_dwords == 10'h000 |=> region == REGION_WINDOW)
    else $error("zero left region not at edge");
  a_adjust_24bpp: assert property (@(posedge clk) disable iff (!rst_n)
    graphics_bpp == BPP_24 |-> window_pixel_adjust == 6'h00)
    else $error("byte adjust used at 24 bpp");
  a_pitch_step: assert property (@(posedge clk) disable iff (!rst_n)
    line_pulse && in_lines && line_sync2 != window_vertical_start |=>
    line_base == $past(line_base) + {10'h000, video_line_offset})
    else $error("line base not stepped by pitch");
  a_offset_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
    video_line_offset[2:0] == 3'b000)
    else $error("line offset low bits set");
  a_fixed_buffer: assert property (@(posedge clk) disable iff (!rst_n)
    line_pulse && line_sync2 == window_vertical_start &&
    buffer_switch_control[4:3] == 2'b01 |=> display_buffer)
    else $error("fixed buffer two not selected");
  a_fetch_count: assert property (@(posedge clk) disable iff (!rst_n)
    video_fetch |-> video_count <= {1'b0, video_source_dword_count})
    else $error("too many video dwords fetched");
  c_window_shown: cover property (@(posedge clk) show_video);
  c_buffer_swap: cover property (@(posedge clk) $changed(display_buffer));
  c_video_fetch: cover property (@(posedge clk) video_fetch);
endmodule
`default_nettype wire

// >>> verification/display_timing_model.sv
// display refresh timing source feeding the video window block
`timescale 1ns/1ps
`default_nettype none
module display_timing_model #(
  parameter int LINE_DWORDS = 8,
  parameter int FRAME_LINES = 260
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // refresh timing
  output logic vsync,
  output logic line_start,
  output logic [9:0] scanline,
  output logic dword_strobe
);
  // four clocks per dword keeps strobes clear of the two-flop synchronisers
  localparam int LINE_CLKS = LINE_DWORDS * 4 + 4;
  logic [7:0] pos;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos <= 8'h00;
      scanline <= 10'h000;
    end else if (pos == 8'(LINE_CLKS - 1)) begin
      pos <= 8'h00;
      scanline <= (scanline == 10'(FRAME_LINES - 1)) ? 10'h000 : scanline + 10'h001;
    end else begin
      pos <= pos + 8'h01;
    end
  end
  // scanline is held for the whole line, so it is stable around line_start
  assign line_start = (pos < 8'h02);
  assign dword_strobe = (pos >= 8'h04) && (pos[1:0] == 2'b00);
  // vsync rises at the start of the last line of each frame
  assign vsync = (scanline == 10'(FRAME_LINES - 1));
endmodule
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the video window overlay fetch block
`timescale 1ns/1ps
`default_nettype none
`include "vwin_params.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
  import vwin_pkg::*;
  localparam int LINES = 260;
  localparam logic [21:0] BUF1 = {4'ha, 8'haf, 8'h35, 2'b01};
  localparam logic [21:0] BUF2 = {4'h3, 8'h40, 8'h12, 2'b01};
  localparam logic [21:0] PITCH = 22'h000890;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, blit_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic vsync, line_start, dword_strobe, graphics_fetch, video_fetch, show_video, display_buffer;
  logic [9:0] scanline;
  logic [21:0] video_addr;
  logic [5:0] window_pixel_adjust;
  bpp_type graphics_bpp;
  logic interlaced, b0;
  int err_count, checks;
  int vid_cnt [LINES];
  int gfx_cnt [LINES];
  int gfx_pre [LINES];
  int sv_cnt [LINES];
  logic [21:0] first_addr [LINES];
  logic [21:0] last_addr [LINES];
  // window 257..258 exercises the overflow bits; src 6 = 12 px / 2 px per dword
  logic [11:0] cfg_a [16] = '{`OFS_LEFT_REGION_SIZE, `OFS_WINDOW_WIDTH, `OFS_VIDEO_SOURCE_SIZE,
    `OFS_HORIZONTAL_OVERFLOW, `OFS_VERTICAL_START, `OFS_VERTICAL_END, `OFS_VERTICAL_OVERFLOW,
    `OFS_BUFFER_ONE_LOW, `OFS_BUFFER_ONE_MID, `OFS_BUFFER_ONE_HIGH, `OFS_LINE_OFFSET_LOW,
    `OFS_ADJUST_BITS, `OFS_BUFFER_TWO_HIGH, `OFS_BUFFER_TWO_LOW, `OFS_BUFFER_TWO_MID,
    `OFS_WINDOW_CONTROL};
  logic [7:0] cfg_d [16] = '{8'h02, 8'h03, 8'h06, 8'h00, 8'h01, 8'h02, 8'h05, 8'h35, 8'haf,
    8'h2a, 8'h12, 8'h04, 8'h03, 8'h12, 8'h40, 8'h01};

  display_timing_model #(.LINE_DWORDS(8), .FRAME_LINES(LINES)) timing (
    .clk(clk), .rst_n(rst_n), .vsync(vsync), .line_start(line_start),
    .scanline(scanline), .dword_strobe(dword_strobe));

  video_window_overlay_fetch uut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vsync(vsync), .line_start(line_start), .scanline(scanline),
    .dword_strobe(dword_strobe), .graphics_bpp(graphics_bpp), .interlaced(interlaced),
    .blit_done(blit_done), .graphics_fetch(graphics_fetch), .video_fetch(video_fetch),
    .video_addr(video_addr), .show_video(show_video),
    .window_pixel_adjust(window_pixel_adjust), .display_buffer(display_buffer));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // per-scanline tallies of what the block asks for
  always @(posedge clk) begin
    if (video_fetch === 1'b1) begin
      if (vid_cnt[scanline] == 0) first_addr[scanline] = video_addr;
      last_addr[scanline] = video_addr;
      vid_cnt[scanline]++;
    end
    if (graphics_fetch === 1'b1) begin
      gfx_cnt[scanline]++;
      if (vid_cnt[scanline] == 0) gfx_pre[scanline]++;
    end
    if (show_video === 1'b1) sv_cnt[scanline]++;
  end

  task automatic close_out();
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      err_count++;
      close_out();
    end
  endtask

  task automatic wait_for(input int line);
    int n;
    n = 0;
    while (scanline !== line[9:0] && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      err_count++;
      close_out();
    end
  endtask

  // one full frame of tallies, lines 0 up to the vsync line
  task automatic run_frame();
    wait_for(LINES - 1);
    wait_for(0);
    foreach (vid_cnt[i]) begin
      vid_cnt[i] = 0;
      gfx_cnt[i] = 0;
      gfx_pre[i] = 0;
      sv_cnt[i] = 0;
    end
    wait_for(LINES - 1);
  endtask

  task automatic check_frame(input logic [21:0] start, input int gfx_win);
    `CHK(vid_cnt[256], 0)
    `CHK(vid_cnt[257], 6)
    `CHK(vid_cnt[258], 6)
    `CHK(sv_cnt[256] == 0 && sv_cnt[257] > 0 && sv_cnt[258] > 0, 1'b1)
    `CHK(gfx_cnt[256], 8)
    `CHK(gfx_pre[257], 2)
    `CHK(gfx_cnt[257], gfx_win)
    `CHK(first_addr[257], start)
    `CHK(last_addr[257], start + 22'd20)
    `CHK(first_addr[258], start + PITCH)
  endtask

  task automatic scen_regs();
    for (int i = 0; i <= 'h40; i += 4) begin
      apb(1'b0, 12'(i), 8'h00);
      `CHK(q, 32'h0)
    end
    // region runs even while disabled; read status once the line has left it
    wait_for(2);
    repeat (16) @(posedge clk);
    apb(1'b0, `OFS_STATUS, 8'h00);
    `CHK(q, 32'h0)
    apb(1'b1, `OFS_VERTICAL_START, 8'ha5);
    apb(1'b0, `OFS_VERTICAL_START, 8'h00);
    `CHK(q, 32'h000000a5)
    apb(1'b1, 12'h080, 8'hff);
    apb(1'b0, 12'h080, 8'h00);
    `CHK(q, 32'h0)
  endtask

  // enable is written mid-frame and must wait for the next vsync
  task automatic scen_enable();
    wait_for(10);
    foreach (cfg_a[i]) apb(1'b1, cfg_a[i], cfg_d[i]);
    apb(1'b0, `OFS_STATUS, 8'h00);
    `CHK(q[0], 1'b0)
    wait_for(LINES - 1);
    wait_for(0);
    apb(1'b0, `OFS_STATUS, 8'h00);
    `CHK(q[0], 1'b1)
    run_frame();
    check_frame(BUF1, 5);
    `CHK(display_buffer, 1'b0)
  endtask

  // fixed swap with occlusion on, then automatic and blit-triggered swaps
  task automatic scen_buffers();
    apb(1'b1, `OFS_SWITCH_CONTROL, 8'h08);
    apb(1'b1, `OFS_WINDOW_CONTROL, 8'h81);
    run_frame();
    check_frame(BUF2, 8);
    `CHK(display_buffer, 1'b1)
    apb(1'b1, `OFS_SWITCH_CONTROL, 8'h10);
    run_frame();
    b0 = display_buffer;
    `CHK(first_addr[257], b0 ? BUF2 : BUF1)
    run_frame();
    `CHK(display_buffer, ~b0)
    apb(1'b1, `OFS_SWITCH_CONTROL, 8'h18);
    run_frame();
    b0 = display_buffer;
    blit_done <= 1'b1;
    repeat (3) @(posedge clk);
    blit_done <= 1'b0;
    run_frame();
    `CHK(display_buffer, ~b0)
  endtask

  // adjust bytes as pixels per graphics depth; none at 24 bpp
  task automatic scen_adjust();
    int n;
    apb(1'b1, `OFS_ADJUST_BITS, 8'h36);
    graphics_bpp <= BPP_16;
    @(posedge clk);
    `CHK(window_pixel_adjust, 6'h01)
    graphics_bpp <= BPP_24;
    @(posedge clk);
    `CHK(window_pixel_adjust, 6'h00)
    graphics_bpp <= BPP_8;
    wait_for(257);
    repeat (4) @(posedge clk);
    `CHK(window_pixel_adjust, 6'h02)
    n = 0;
    while (show_video !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    `CHK(n < 200, 1'b1)
    `CHK(window_pixel_adjust, 6'h03)
  endtask

  initial begin
    err_count = 0;
    checks = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    blit_done = 1'b0;
    interlaced = 1'b0;
    graphics_bpp = BPP_8;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    scen_regs();
    scen_enable();
    scen_buffers();
    scen_adjust();
    close_out();
  end
endmodule
`default_nettype wire
